// [design/fcls_pkg.sv]
// constants and types shared by the configuration lock block
package fcls_pkg;
	// configuration byte field positions
	localparam int CFG_DOUBLE_SPEED_BIT = 7;
	localparam int CFG_LOADER_JUMP_BIT  = 6;
	localparam int CFG_AUX_RAM_BIT      = 3;
	localparam int CFG_LOCK2_BIT        = 2;
	localparam int CFG_LOCK1_BIT        = 1;
	localparam int CFG_LOCK0_BIT        = 0;
	// shipped and erased values of the non-volatile bytes
	localparam logic [7:0] CFG_SHIPPED      = 8'hbb;
	localparam logic [7:0] CFG_ERASED       = 8'hff;
	localparam logic [7:0] SEC_RESET        = 8'hff;
	localparam logic [7:0] VECTOR_RESET     = 8'hfc;
	localparam logic [7:0] BOOT_STAT_RESET  = 8'hff;
	localparam logic [7:0] BYTE_ERASED      = 8'hff;
	localparam logic [7:0] SEC_RSVD_MASK    = 8'hfc;
	// start addresses selected at reset
	localparam logic [15:0] APP_START       = 16'h0000;
	localparam logic [15:0] LOADER_START    = 16'hf800;
	// clocks per instruction for each speed mode
	localparam logic [3:0] CLK_DOUBLE       = 4'h6;
	localparam logic [3:0] CLK_STANDARD     = 4'hc;
	// extra page indices
	localparam logic [1:0] XP_VECTOR        = 2'h0;
	localparam logic [1:0] XP_BOOT_STAT     = 2'h1;
	localparam logic [1:0] XP_SECURITY      = 2'h2;
	localparam logic [1:0] XP_CONFIG        = 2'h3;
	// part identification, value arbitrary
	localparam logic [7:0] PART_ID          = 8'h3c;
	// parallel programming commands
	typedef enum logic [2:0] {
		PCMD_NONE       = 3'b000,
		PCMD_WRITE_CODE = 3'b001,
		PCMD_VERIFY     = 3'b010,
		PCMD_WRITE_XP   = 3'b011,
		PCMD_READ_XP    = 3'b100,
		PCMD_READ_ID    = 3'b101,
		PCMD_CHIP_ERASE = 3'b110
	} fcls_pcmd_t;
	// lock levels of the parallel interface
	typedef enum logic [1:0] {
		LVL_ONE   = 2'b00,
		LVL_TWO   = 2'b01,
		LVL_THREE = 2'b10,
		LVL_FOUR  = 2'b11
	} fcls_level_t;
endpackage : fcls_pkg

// [design/fcls_lock_if.sv]
// decoded lock permissions passed between the top and its decoder
`timescale 1ns/1ps
`default_nettype none
interface fcls_lock_if;
	logic [2:0] parLock;      // parallel lock field
	logic [1:0] ispLock;      // isp lock field
	logic       parWriteOk;
	logic       parVerifyOk;
	logic       extExecOk;
	logic       codeReadOk;
	logic       ispWriteOk;
	logic       ispVerifyOk;
	fcls_pkg::fcls_level_t parLevel;
	modport ctrl (output parLock, ispLock, input parWriteOk, parVerifyOk, extExecOk, codeReadOk,
		ispWriteOk, ispVerifyOk, parLevel);
	modport dec (input parLock, ispLock, output parWriteOk, parVerifyOk, extExecOk, codeReadOk,
		ispWriteOk, ispVerifyOk, parLevel);
endinterface : fcls_lock_if
`default_nettype wire

// [design/fcls_lock_decode.sv]
// decodes the lock fields into permissions
`timescale 1ns/1ps
`default_nettype none
module fcls_lock_decode (
	fcls_lock_if.dec lk    // lock fields in, permissions out
);
	// parallel level: highest programmed bit wins, lower bits ignored
	always_comb begin
		if (!lk.parLock[2]) begin
			lk.parLevel = fcls_pkg::LVL_FOUR;
		end else if (!lk.parLock[1]) begin
			lk.parLevel = fcls_pkg::LVL_THREE;
		end else if (!lk.parLock[0]) begin
			lk.parLevel = fcls_pkg::LVL_TWO;
		end else begin
			lk.parLevel = fcls_pkg::LVL_ONE;
		end
	end
	assign lk.parWriteOk  = (lk.parLevel == fcls_pkg::LVL_ONE);
	assign lk.codeReadOk  = (lk.parLevel == fcls_pkg::LVL_ONE);
	assign lk.parVerifyOk = (lk.parLevel == fcls_pkg::LVL_ONE) || (lk.parLevel == fcls_pkg::LVL_TWO);
	assign lk.extExecOk   = (lk.parLevel != fcls_pkg::LVL_FOUR);
	assign lk.ispWriteOk  = lk.ispLock[0] && lk.ispLock[1];
	assign lk.ispVerifyOk = lk.ispLock[1];
endmodule : fcls_lock_decode
`default_nettype wire

// [design/flash_config_lock_security.sv]
// configuration byte, isp security byte and lock enforcement for the program flash
`timescale 1ns/1ps
`default_nettype none
module flash_config_lock_security (
	input  wire logic        clk,            // 200 MHz clock
	input  wire logic        rst_n,          // async reset, active low
	input  wire logic        extAccessPin,   // external access pin, asynchronous
	input  wire logic [2:0]  parCmd,         // parallel programming command
	input  wire logic [1:0]  parAddr,        // extra page index for parallel access
	input  wire logic [7:0]  parWrData,      // parallel write data
	output logic      [7:0]  parRdData,      // parallel read data
	output logic             parAck,         // parallel command accepted pulse
	output logic             parRefused,     // parallel command refused pulse
	input  wire logic        ispWrite,       // isp/api write request
	input  wire logic        ispRead,        // isp/api read request
	input  wire logic [1:0]  ispAddr,        // extra page index for isp access
	input  wire logic [7:0]  ispWrData,      // isp write data
	input  wire logic        ispFlashWrite,  // isp flash program request
	input  wire logic        ispFlashVerify, // isp flash verify request
	output logic      [7:0]  ispRdData,      // isp read data
	output logic             ispAck,         // isp request accepted pulse
	output logic             ispRefused,     // isp request refused pulse
	input  wire logic        extCodeRead,    // code read from external memory
	output logic             codeReadAllow,  // code read may return internal bytes
	output logic             extExecAllow,   // external execution allowed
	output logic             doubleSpeed,    // six-clock mode active
	output logic      [3:0]  clocksPerInstr, // clocks per instruction
	output logic      [15:0] startAddr,      // reset start address
	output logic             auxRamEnable,   // auxiliary RAM enabled
	output logic             extAccessLatch, // latched external access level
	output logic             flashErased     // pulse when chip erase done
);
	logic [7:0] bootCfg_reg;      // non-volatile configuration byte
	logic [7:0] secByte_reg;      // isp security byte
	logic [7:0] vector_reg;       // loader vector
	logic [7:0] bootStat_reg;     // boot status byte
	logic [7:0] liveCfg_reg;      // settings captured at reset
	logic       captured_reg;     // capture done after release
	logic       extSync1_reg;
	logic       extSync2_reg;
	logic       eaFrozen_reg;     // frozen external access level
	logic [1:0] eaWait_reg;       // edges since release, until the pin sample is settled
	fcls_lock_if lk ();

	fcls_lock_decode u_dec (
		.lk (lk)
	);

	// parallel lock from config, isp lock from security byte only
	assign lk.parLock = liveCfg_reg[fcls_pkg::CFG_LOCK2_BIT:fcls_pkg::CFG_LOCK0_BIT];
	assign lk.ispLock = secByte_reg[1:0];

	// external access pin synchroniser
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			extSync1_reg <= 1'b0;
			extSync2_reg <= 1'b0;
		end else begin
			extSync1_reg <= extAccessPin;
			extSync2_reg <= extSync1_reg;
		end
	end

	// capture settings on the first edge after release, hold until reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			liveCfg_reg  <= fcls_pkg::CFG_SHIPPED;
			captured_reg <= 1'b0;
		end else if (!captured_reg) begin
			liveCfg_reg  <= bootCfg_reg;
			captured_reg <= 1'b1;
		end
	end

	// external access level frozen once the synchroniser holds the pin
	// sampling at the first edge would take the synchroniser's reset value, not the pin
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			eaWait_reg   <= 2'h0;
			eaFrozen_reg <= 1'b0;
		end else if (eaWait_reg != 2'h3) begin
			eaWait_reg <= eaWait_reg + 2'h1;
			if (eaWait_reg == 2'h2) begin
				eaFrozen_reg <= extSync2_reg;
			end
		end
	end

	// configuration byte changed only by parallel commands
	// chip erase returns byte to inactive state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bootCfg_reg <= fcls_pkg::CFG_SHIPPED;
		end else if (parCmd == fcls_pkg::PCMD_CHIP_ERASE) begin
			bootCfg_reg <= fcls_pkg::CFG_ERASED;
		end else if (parCmd == fcls_pkg::PCMD_WRITE_XP && parAddr == fcls_pkg::XP_CONFIG && lk.parWriteOk) begin
			bootCfg_reg <= parWrData;
		end
	end

	// extra page bytes reached from parallel or isp/api
	// reserved security bits kept at one against a careless write
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			secByte_reg  <= fcls_pkg::SEC_RESET;
			vector_reg   <= fcls_pkg::VECTOR_RESET;
			bootStat_reg <= fcls_pkg::BOOT_STAT_RESET;
		end else if (parCmd == fcls_pkg::PCMD_CHIP_ERASE) begin
			secByte_reg  <= fcls_pkg::BYTE_ERASED;
			vector_reg   <= fcls_pkg::BYTE_ERASED;
			bootStat_reg <= fcls_pkg::BYTE_ERASED;
		end else if (parCmd == fcls_pkg::PCMD_WRITE_XP && lk.parWriteOk) begin
			unique case (parAddr)
				fcls_pkg::XP_VECTOR:    vector_reg   <= parWrData;
				fcls_pkg::XP_BOOT_STAT: bootStat_reg <= parWrData;
				fcls_pkg::XP_SECURITY:  secByte_reg  <= parWrData | fcls_pkg::SEC_RSVD_MASK;
				fcls_pkg::XP_CONFIG:    ;
			endcase
		end else if (ispWrite && lk.ispWriteOk) begin
			unique case (ispAddr)
				fcls_pkg::XP_VECTOR:    vector_reg   <= ispWrData;
				fcls_pkg::XP_BOOT_STAT: bootStat_reg <= ispWrData;
				// security only tightens from isp: bits may clear, never set
				fcls_pkg::XP_SECURITY:  secByte_reg  <= (secByte_reg & ispWrData) | fcls_pkg::SEC_RSVD_MASK;
				fcls_pkg::XP_CONFIG:    ;
			endcase
		end else if (ispWrite && ispAddr == fcls_pkg::XP_SECURITY) begin
			secByte_reg <= (secByte_reg & ispWrData) | fcls_pkg::SEC_RSVD_MASK;
		end
	end

	// parallel answer path
	// identification always returned
	// verify refused at level three and up
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			parRdData  <= 8'h00;
			parAck     <= 1'b0;
			parRefused <= 1'b0;
		end else begin
			parAck     <= 1'b0;
			parRefused <= 1'b0;
			unique case (parCmd)
				fcls_pkg::PCMD_READ_ID: begin
					parRdData <= fcls_pkg::PART_ID;
					parAck    <= 1'b1;
				end
				fcls_pkg::PCMD_VERIFY, fcls_pkg::PCMD_READ_XP: begin
					if (lk.parVerifyOk) begin
						parRdData <= xpRead(parAddr);
						parAck    <= 1'b1;
					end else begin
						parRdData  <= 8'h00;
						parRefused <= 1'b1;
					end
				end
				fcls_pkg::PCMD_WRITE_CODE, fcls_pkg::PCMD_WRITE_XP: begin
					parAck     <= lk.parWriteOk;
					parRefused <= !lk.parWriteOk;
				end
				fcls_pkg::PCMD_CHIP_ERASE: parAck <= 1'b1;
				default: ;
			endcase
		end
	end

	// isp answer path
	// isp writes refused under lock or to the configuration byte; security byte writes always accepted
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ispRdData  <= 8'h00;
			ispAck     <= 1'b0;
			ispRefused <= 1'b0;
		end else begin
			ispAck     <= 1'b0;
			ispRefused <= 1'b0;
			if (ispFlashWrite || (ispWrite && ispAddr != fcls_pkg::XP_SECURITY)) begin
				ispAck     <= lk.ispWriteOk && ispAddr != fcls_pkg::XP_CONFIG;
				ispRefused <= !(lk.ispWriteOk && ispAddr != fcls_pkg::XP_CONFIG);
			end else if (ispWrite) begin
				ispAck <= 1'b1;
			end else if (ispFlashVerify || ispRead) begin
				if (lk.ispVerifyOk && ispAddr != fcls_pkg::XP_CONFIG) begin
					ispRdData <= xpRead(ispAddr);
					ispAck    <= 1'b1;
				end else begin
					ispRdData  <= 8'h00;
					ispRefused <= 1'b1;
				end
			end
		end
	end

	// extra page read decode, shared by both paths
	function automatic logic [7:0] xpRead(input logic [1:0] idx);
		unique case (idx)
			fcls_pkg::XP_VECTOR:    xpRead = vector_reg;
			fcls_pkg::XP_BOOT_STAT: xpRead = bootStat_reg;
			fcls_pkg::XP_SECURITY:  xpRead = secByte_reg;
			fcls_pkg::XP_CONFIG:    xpRead = bootCfg_reg;
		endcase
	endfunction : xpRead

	// decoded reset settings, registered so outputs come from flops
	// speed mode
	// code reads and external access latch
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			doubleSpeed    <= 1'b0;
			clocksPerInstr <= fcls_pkg::CLK_STANDARD;
			startAddr      <= fcls_pkg::LOADER_START;
			auxRamEnable   <= 1'b1;
			codeReadAllow  <= 1'b0;
			extExecAllow   <= 1'b0;
			extAccessLatch <= 1'b0;
		end else begin
			doubleSpeed    <= !liveCfg_reg[fcls_pkg::CFG_DOUBLE_SPEED_BIT];
			clocksPerInstr <= liveCfg_reg[fcls_pkg::CFG_DOUBLE_SPEED_BIT] ? fcls_pkg::CLK_STANDARD
				: fcls_pkg::CLK_DOUBLE;
			startAddr      <= liveCfg_reg[fcls_pkg::CFG_LOADER_JUMP_BIT] ? fcls_pkg::APP_START
				: fcls_pkg::LOADER_START;
			auxRamEnable   <= liveCfg_reg[fcls_pkg::CFG_AUX_RAM_BIT];
			codeReadAllow  <= !extCodeRead || lk.codeReadOk;
			extExecAllow   <= lk.extExecOk;
			// unlocked parts follow the pin live; locked ones keep the reset sample
			extAccessLatch <= lk.codeReadOk ? extSync2_reg : eaFrozen_reg;
		end
	end

	// erase done indication
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flashErased <= 1'b0;
		end else begin
			flashErased <= (parCmd == fcls_pkg::PCMD_CHIP_ERASE);
		end
	end

	// assertions
	AST_SPEED: assert property (@(posedge clk) disable iff (!rst_n)
		captured_reg |=> doubleSpeed == !liveCfg_reg[7] && (doubleSpeed -> clocksPerInstr == 4'h6))
		else $error("speed mode does not follow configuration");
	AST_START: assert property (@(posedge clk) disable iff (!rst_n)
		captured_reg && $stable(liveCfg_reg) |=> startAddr == (liveCfg_reg[6] ? 16'h0000 : 16'hf800))
		else $error("start address wrong");
	AST_AUXRAM: assert property (@(posedge clk) disable iff (!rst_n)
		captured_reg |=> auxRamEnable == $past(liveCfg_reg[3]))
		else $error("aux ram enable wrong");
	AST_OPEN: assert property (@(posedge clk) disable iff (!rst_n)
		parCmd == 3'b001 && liveCfg_reg[2:0] == 3'b111 |=> parAck && !parRefused)
		else $error("unlocked write refused");
	AST_PARWR: assert property (@(posedge clk) disable iff (!rst_n)
		parCmd == 3'b001 && liveCfg_reg[2:0] != 3'b111 |=> parRefused && !parAck)
		else $error("locked parallel write accepted");
	AST_PARVFY: assert property (@(posedge clk) disable iff (!rst_n)
		parCmd == 3'b010 && (!liveCfg_reg[1] || !liveCfg_reg[2]) |=> parRefused && !parAck)
		else $error("locked verify accepted");
	AST_EXTEXE: assert property (@(posedge clk) disable iff (!rst_n)
		!liveCfg_reg[2] |=> !extExecAllow)
		else $error("external execution at level four");
	AST_ERASE: assert property (@(posedge clk) disable iff (!rst_n)
		parCmd == 3'b110 |=> bootCfg_reg == 8'hff && flashErased)
		else $error("erase did not clear configuration");
	AST_PARTID: assert property (@(posedge clk) disable iff (!rst_n)
		parCmd == 3'b101 |=> parAck && parRdData == fcls_pkg::PART_ID)
		else $error("identification not returned");
	AST_ISPWR: assert property (@(posedge clk) disable iff (!rst_n)
		ispFlashWrite && !secByte_reg[0] |=> ispRefused)
		else $error("isp write accepted under lock");
	AST_ISPVFY: assert property (@(posedge clk) disable iff (!rst_n)
		ispFlashVerify && !ispFlashWrite && !ispWrite && !secByte_reg[1] |=> ispRefused)
		else $error("isp verify accepted under lock");
	AST_ISPCFG: assert property (@(posedge clk) disable iff (!rst_n)
		ispRead && ispAddr == 2'h3 && !ispWrite && !ispFlashWrite |=> ispRefused && !ispAck)
		else $error("configuration byte reached from isp");
	AST_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
		captured_reg |=> $stable(liveCfg_reg))
		else $error("captured settings changed");
	COV_ERASE: cover property (@(posedge clk) disable iff (!rst_n) parCmd == 3'b110 ##1 parCmd == 3'b011);
	COV_ISPLOCK: cover property (@(posedge clk) disable iff (!rst_n) ispRefused);
	COV_VERIFY: cover property (@(posedge clk) disable iff (!rst_n) parCmd == 3'b010 ##1 parAck);
endmodule : flash_config_lock_security
`default_nettype wire

// [tb/fcls_programmer.sv]
// programmer and isp firmware model facing the flash lock block
`timescale 1ns/1ps
`default_nettype none
module fcls_programmer (
	input  wire logic       clk,            // system clock
	output logic      [2:0] parCmd,         // parallel command
	output logic      [1:0] parAddr,        // parallel extra page index
	output logic      [7:0] parWrData,      // parallel write data
	input  wire logic [7:0] parRdData,      // parallel read data
	input  wire logic       parAck,         // parallel accept
	input  wire logic       parRefused,     // parallel refuse
	output logic            ispWrite,       // isp register write
	output logic            ispRead,        // isp register read
	output logic      [1:0] ispAddr,        // isp extra page index
	output logic      [7:0] ispWrData,      // isp write data
	output logic            ispFlashWrite,  // isp flash program
	output logic            ispFlashVerify, // isp flash verify
	input  wire logic [7:0] ispRdData,      // isp read data
	input  wire logic       ispAck,         // isp accept
	input  wire logic       ispRefused      // isp refuse
);
	initial begin
		{parCmd, parAddr, parWrData, ispWrite, ispRead} = '0;
		{ispAddr, ispWrData, ispFlashWrite, ispFlashVerify} = '0;
	end
	// request lasts one cycle; released data lines show the inverse so stale values never match
	task automatic waitAnswer(input bit isp, output logic ok, output logic refused, output logic [7:0] rd);
		ok = 1'b0;
		refused = 1'b0;
		rd = 8'h00;
		for (int i = 0; i < 3; i++) begin
			@(posedge clk);
			#1;
			if (i == 0) begin
				{parCmd, ispWrite, ispRead, ispFlashWrite, ispFlashVerify} = '0;
				parWrData = ~parWrData;
				ispWrData = ~ispWrData;
			end
			if (isp ? (ispAck === 1'b1 || ispRefused === 1'b1) : (parAck === 1'b1 || parRefused === 1'b1)) begin
				ok = isp ? ispAck : parAck;
				refused = isp ? ispRefused : parRefused;
				rd = isp ? ispRdData : parRdData;
				break;
			end
		end
	endtask : waitAnswer
	task automatic parOp(input logic [2:0] c, input logic [1:0] a, input logic [7:0] d,
		output logic ok, output logic refused, output logic [7:0] rd);
		parCmd = c;
		parAddr = a;
		parWrData = d;
		waitAnswer(1'b0, ok, refused, rd);
	endtask : parOp
	// kind 0 write, 1 read, 2 flash program, 3 flash verify
	task automatic ispOp(input int kind, input logic [1:0] a, input logic [7:0] d,
		output logic ok, output logic refused, output logic [7:0] rd);
		ispAddr = a;
		ispWrData = (a == 2'h2) ? (d | 8'hfc) : d;
		ispWrite = (kind == 0);
		ispRead = (kind == 1);
		ispFlashWrite = (kind == 2);
		ispFlashVerify = (kind == 3);
		waitAnswer(1'b1, ok, refused, rd);
	endtask : ispOp
endmodule : fcls_programmer
`default_nettype wire

// [tb/flash_config_lock_security_tb.sv]
// self-checking bench for the configuration lock block
`timescale 1ns/1ps
`default_nettype none
module flash_config_lock_security_tb;
	logic        clk, rst_n, extAccessPin, extCodeRead, parAck, parRefused, ispWrite, ispRead;
	logic        ispFlashWrite, ispFlashVerify, ispAck, ispRefused, codeReadAllow, extExecAllow;
	logic        doubleSpeed, auxRamEnable, extAccessLatch, flashErased;
	logic [2:0]  parCmd;
	logic [1:0]  parAddr, ispAddr;
	logic [7:0]  parWrData, parRdData, ispWrData, ispRdData, cfgMdl, secMdl;
	logic [7:0]  xpMdl [2];
	logic [3:0]  clocksPerInstr;
	logic [15:0] startAddr;
	int          n_mismatch = 0, n_tests = 0, nErase = 0;
	logic        ok, refused, exp;
	logic [7:0]  rd;
	int          lvl;
	flash_config_lock_security dut_u (.clk(clk), .rst_n(rst_n), .extAccessPin(extAccessPin), .parCmd(parCmd),
		.parAddr(parAddr), .parWrData(parWrData), .parRdData(parRdData), .parAck(parAck),
		.parRefused(parRefused), .ispWrite(ispWrite), .ispRead(ispRead), .ispAddr(ispAddr),
		.ispWrData(ispWrData), .ispFlashWrite(ispFlashWrite), .ispFlashVerify(ispFlashVerify),
		.ispRdData(ispRdData), .ispAck(ispAck), .ispRefused(ispRefused), .extCodeRead(extCodeRead),
		.codeReadAllow(codeReadAllow), .extExecAllow(extExecAllow), .doubleSpeed(doubleSpeed),
		.clocksPerInstr(clocksPerInstr), .startAddr(startAddr), .auxRamEnable(auxRamEnable),
		.extAccessLatch(extAccessLatch), .flashErased(flashErased));
	fcls_programmer prog_u (.clk(clk), .parCmd(parCmd), .parAddr(parAddr), .parWrData(parWrData),
		.parRdData(parRdData), .parAck(parAck), .parRefused(parRefused), .ispWrite(ispWrite),
		.ispRead(ispRead), .ispAddr(ispAddr), .ispWrData(ispWrData), .ispFlashWrite(ispFlashWrite),
		.ispFlashVerify(ispFlashVerify), .ispRdData(ispRdData), .ispAck(ispAck), .ispRefused(ispRefused));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// erase pulses counted as they stand for one cycle only
	always @(posedge clk) begin
		if (flashErased === 1'b1) nErase++;
	end
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] expv);
		n_tests++;
		if (seen !== expv) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, expv, seen);
		end
	endtask : check
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : test_done
	// reset restores the shipped bytes in the model as in the block
	task automatic doReset;
		rst_n = 1'b0;
		repeat (20) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		cfgMdl = 8'hbb;
		secMdl = 8'hff;
		xpMdl[0] = 8'hfc;
		xpMdl[1] = 8'hff;
		lvl = !cfgMdl[2] ? 4 : !cfgMdl[1] ? 3 : !cfgMdl[0] ? 2 : 1;
	endtask : doReset
	// decoded settings follow the captured configuration byte
	task automatic checkDecode;
		check("doubleSpeed", doubleSpeed, !cfgMdl[7]);
		check("clocksPerInstr", clocksPerInstr, cfgMdl[7] ? 4'hc : 4'h6);
		check("startAddr", startAddr, cfgMdl[6] ? 16'h0000 : 16'hf800);
		check("auxRamEnable", auxRamEnable, cfgMdl[3]);
		check("extExecAllow", extExecAllow, lvl < 4);
	endtask : checkDecode
	task automatic ispStep(input int kind, input logic [1:0] a, input logic [7:0] d);
		logic wp, rp;
		wp = !secMdl[0] || !secMdl[1];
		rp = !secMdl[1];
		case (kind)
			0: exp = (a == 2'h2) || (a != 2'h3 && !wp);
			1: exp = (a != 2'h3) && !rp;
			2: exp = !wp;
			default: exp = !rp;
		endcase
		prog_u.ispOp(kind, a, d, ok, refused, rd);
		check("isp ack", ok, exp);
		check("isp refused", refused, !exp);
		if (exp && kind == 1) check("isp data", rd, (a == 2'h2) ? secMdl : xpMdl[a[0]]);
		if (exp && kind == 0 && a == 2'h2) secMdl = secMdl & (d | 8'hfc);
		else if (exp && kind == 0) xpMdl[a[0]] = d;
	endtask : ispStep
	initial begin
		#50000;
		n_mismatch++;
		test_done();
	end
	initial begin
		logic [2:0] cmds [5];
		cmds = '{3'h5, 3'h1, 3'h2, 3'h3, 3'h4};
		rst_n = 1'b0;
		extAccessPin = 1'b1;
		extCodeRead = 1'b0;
		void'($urandom(67));
		@(posedge clk);
		#1;
		doReset();
		checkDecode();
		// external access sampled at reset stays latched
		extAccessPin = 1'b0;
		repeat (6) @(posedge clk);
		#1;
		check("extAccessLatch", extAccessLatch, 1'b1);
		for (int i = 0; i < 6; i++) begin
			extCodeRead = $urandom % 2;
			repeat (2) @(posedge clk);
			#1;
			check("codeReadAllow", codeReadAllow, !extCodeRead || lvl == 1);
		end
		// every parallel command except erase against the shipped lock level
		foreach (cmds[i]) begin
			prog_u.parOp(cmds[i], $urandom % 4, $urandom, ok, refused, rd);
			exp = (cmds[i] == 3'h5) || (lvl == 1) || (lvl == 2 && (cmds[i] == 3'h2 || cmds[i] == 3'h4));
			check("par ack", ok, exp);
			check("par refused", refused, !exp);
			if (cmds[i] == 3'h5) check("part id", rd, 8'h3c);
		end
		// isp side ignores the parallel level and obeys the security byte
		ispStep(1, 2'h0, 8'h00);
		ispStep(1, 2'h1, 8'h00);
		ispStep(1, 2'h3, 8'h00);
		ispStep(0, 2'h3, $urandom);
		ispStep(2, 2'h0, 8'h00);
		ispStep(0, 2'h0, $urandom);
		ispStep(1, 2'h0, 8'h00);
		ispStep(0, 2'h1, 8'h00);
		ispStep(1, 2'h1, 8'h00);
		ispStep(3, 2'h0, 8'h00);
		ispStep(0, 2'h2, {6'($urandom), 2'b10});
		ispStep(1, 2'h2, 8'h00);
		ispStep(2, 2'h0, 8'h00);
		ispStep(3, 2'h0, 8'h00);
		ispStep(0, 2'h1, $urandom);
		ispStep(0, 2'h2, {6'($urandom), 2'b00});
		ispStep(3, 2'h0, 8'h00);
		ispStep(1, 2'h0, 8'h00);
		// chip erase clears every byte and ends the isp lock
		prog_u.parOp(3'h6, 2'h0, 8'h00, ok, refused, rd);
		check("erase ack", ok, 1'b1);
		check("erase pulse", flashErased, 1'b1);
		@(posedge clk);
		#1;
		check("erase pulses", nErase, 1);
		secMdl = 8'hff;
		xpMdl[0] = 8'hff;
		xpMdl[1] = 8'hff;
		ispStep(2, 2'h0, 8'h00);
		ispStep(1, 2'h0, 8'h00);
		checkDecode();
		doReset();
		checkDecode();
		test_done();
	end
endmodule : flash_config_lock_security_tb
`default_nettype wire
